/* File: verilog/mwdt_map.svh */
// Register offsets, field positions, reset values and timing counts of the watchdog.
`ifndef MWDT_MAP_SVH
`define MWDT_MAP_SVH
`define MWDT_ADDR_MODE 8'h98
`define MWDT_ADDR_KICK 8'h99
`define MWDT_ADDR_CTRL 8'h9A
`define MWDT_ADDR_STAT 8'h9B
`define MWDT_MODE_RESET 8'h67
`define MWDT_KICK_READ 8'h9A
`define MWDT_KICK_KEY 8'hAC
`define MWDT_FIXED_HI 3'h3
`define MWDT_CS_HI 4
`define MWDT_CS_LO 3
`define MWDT_LOW_EXP_BASE 11
`define MWDT_X1_EXP_BASE 13
`define MWDT_CNT_W 21
`define MWDT_OST_W 16
`define MWDT_OST_RESET 16'h0100
`endif

/* File: verilog/mwdt_pkg.sv */
// Types shared by the watchdog top and its bench.
`default_nettype none
package mwdt_pkg;
  typedef enum logic [1:0] {
    MWDT_SRC_LOW = 2'h0,
    MWDT_SRC_X1 = 2'h1,
    MWDT_SRC_STOP = 2'h2
  } mwdt_src_t;
  typedef enum logic [3:0] {
    MWDT_ST_RUN = 4'h1,
    MWDT_ST_HALT = 4'h2,
    MWDT_ST_STOP = 4'h4,
    MWDT_ST_WAIT = 4'h8
  } mwdt_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_op;
  } mwdt_bus_t;
  typedef struct packed {
    logic halt;
    logic stop;
    logic cpu_on_x1;
    logic tick_low;
    logic tick_x1;
  } mwdt_cpu_t;
endpackage : mwdt_pkg
`default_nettype wire

/* File: verilog/mwdt_counter.sv */
// Watchdog up-counter with clear, enable and overflow compare.
`timescale 1ns/1ps
`default_nettype none
`include "mwdt_map.svh"
module mwdt_counter #(
  parameter int CNT_W = `MWDT_CNT_W
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Control.
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [4:0] exp_i,
  // Result.
  output logic [CNT_W-1:0] count_o,
  output logic overflow_o
);
  if (CNT_W < 21) begin : g_bad_cnt_w
    $error("mwdt_counter: CNT_W too small");
  end

  logic [CNT_W-1:0] limit;
  assign limit = {{(CNT_W-1){1'b0}}, 1'b1} << exp_i;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= '0;
    end else if (clear_i) begin
      count_o <= '0;
    end else if (step_i) begin
      count_o <= count_o + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign overflow_o = step_i && !clear_i && (count_o == limit - {{(CNT_W-1){1'b0}}, 1'b1});
endmodule : mwdt_counter
`default_nettype wire

/* File: verilog/mwdt_top.sv */
// Watchdog timer top: registers, clock selection, pause control and reset request.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mwdt_map.svh"
module mwdt_top #(
  parameter int CNT_W = `MWDT_CNT_W,
  parameter int OST_W = `MWDT_OST_W
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Factory option: high when the watchdog can be stopped.
  input wire logic stoppable_i,
  // Register port.
  input wire mwdt_pkg::mwdt_bus_t bus_i,
  output logic [7:0] rdata_o,
  // Processor status and clock ticks.
  input wire mwdt_pkg::mwdt_cpu_t cpu_i,
  // Reset request.
  output logic wdt_reset_o
);
  import mwdt_pkg::*;

  // Parameters that the logic cannot serve stop the build.
  if (CNT_W < 21) begin : g_bad_cnt_w
    $error("mwdt_top: CNT_W too small");
  end
  if (OST_W < 1 || OST_W > 16) begin : g_bad_ost_w
    $error("mwdt_top: OST_W out of range");
  end

  // ----------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------
  function automatic mwdt_src_t decode_src(input logic [7:0] mode, input logic stoppable);
    if (!stoppable) begin
      decode_src = MWDT_SRC_LOW;
    end else if (mode[`MWDT_CS_HI]) begin
      decode_src = MWDT_SRC_STOP;
    end else if (mode[`MWDT_CS_LO]) begin
      decode_src = MWDT_SRC_X1;
    end else begin
      decode_src = MWDT_SRC_LOW;
    end
  endfunction : decode_src

  function automatic logic [4:0] period_exp(input logic [2:0] sel, input mwdt_src_t src);
    if (src == MWDT_SRC_X1) begin
      period_exp = 5'(`MWDT_X1_EXP_BASE) + {2'h0, sel};
    end else begin
      period_exp = 5'(`MWDT_LOW_EXP_BASE) + {2'h0, sel};
    end
  endfunction : period_exp

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic [7:0] mode;
  logic mode_written;
  logic [OST_W-1:0] ost_len;
  logic [OST_W-1:0] ost_cnt;
  logic bad_mode_seen;
  logic bad_kick_seen;
  logic ovf_seen;
  mwdt_state_t state;
  mwdt_src_t src;
  logic hit_mode;
  logic hit_kick;
  logic hit_ctrl;
  logic hit_stat;
  logic mode_wr;
  logic kick_wr;
  logic kick_good;
  logic kick_bad;
  logic mode_again;
  logic tick_sel;
  logic step;
  logic clear;
  logic overflow;
  logic [CNT_W-1:0] count;
  logic paused;
  logic cpu_on_x1_at_stop;

  assign hit_mode = bus_i.addr == `MWDT_ADDR_MODE;
  assign hit_kick = bus_i.addr == `MWDT_ADDR_KICK;
  assign hit_ctrl = bus_i.addr == `MWDT_ADDR_CTRL;
  assign hit_stat = bus_i.addr == `MWDT_ADDR_STAT;
  assign src = decode_src(mode, stoppable_i);
  assign mode_wr = bus_i.wr && hit_mode && !bus_i.bit_op;
  assign mode_again = bus_i.wr && hit_mode && (mode_written || bus_i.bit_op) && src != MWDT_SRC_STOP;
  assign kick_wr = bus_i.wr && hit_kick;
  assign kick_good = kick_wr && !bus_i.bit_op && bus_i.wdata == `MWDT_KICK_KEY;
  assign kick_bad = kick_wr && !kick_good && src != MWDT_SRC_STOP;

  // The mode register takes one full-byte write; the upper three bits stay fixed.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode <= `MWDT_MODE_RESET;
      mode_written <= 1'b0;
    end else if (mode_wr && !mode_written) begin
      mode <= {`MWDT_FIXED_HI, bus_i.wdata[4:0]};
      mode_written <= 1'b1;
    end
  end

  // Stabilization length, set by software in an extra register.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ost_len <= OST_W'(`MWDT_OST_RESET);
    end else if (bus_i.wr && hit_ctrl) begin
      ost_len <= OST_W'(bus_i.wdata);
    end
  end

  // ----------------------------------------------------------------
  // Pause state machine.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= MWDT_ST_RUN;
      ost_cnt <= '0;
    end else if (!stoppable_i) begin
      state <= MWDT_ST_RUN;
    end else begin
      case (state)
        MWDT_ST_RUN: begin
          if (cpu_i.stop) begin
            state <= MWDT_ST_STOP;
          end else if (cpu_i.halt) begin
            state <= MWDT_ST_HALT;
          end
        end
        MWDT_ST_HALT: begin
          if (!cpu_i.halt) begin
            state <= MWDT_ST_RUN;
          end
        end
        MWDT_ST_STOP: begin
          if (!cpu_i.stop) begin
            if (src == MWDT_SRC_X1) begin
              state <= MWDT_ST_WAIT;
              ost_cnt <= '0;
            end else begin
              state <= MWDT_ST_RUN;
            end
          end
        end
        // Counting waits for the stabilization time, or for a processor that slept on the low clock to move to X1.
        MWDT_ST_WAIT: begin
          if (cpu_i.tick_x1 && ost_cnt == ost_len - OST_W'(1)) begin
            state <= MWDT_ST_RUN;
          end else if (cpu_i.cpu_on_x1 && !cpu_on_x1_at_stop) begin
            state <= MWDT_ST_RUN;
          end else if (cpu_i.tick_x1) begin
            ost_cnt <= ost_cnt + OST_W'(1);
          end
        end
        default: begin
          state <= MWDT_ST_RUN;
        end
      endcase
    end
  end

  // CPU clock at STOP entry decides which resume events count.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_on_x1_at_stop <= 1'b0;
    end else if (state == MWDT_ST_RUN && cpu_i.stop) begin
      cpu_on_x1_at_stop <= cpu_i.cpu_on_x1;
    end
  end

  // ----------------------------------------------------------------
  // Counter and reset request.
  // ----------------------------------------------------------------
  assign tick_sel = (src == MWDT_SRC_X1) ? cpu_i.tick_x1 : (src == MWDT_SRC_LOW) ? cpu_i.tick_low : 1'b0;
  // A pause covers HALT, STOP and the stabilization wait; on release the count goes on from where it stood.
  assign paused = stoppable_i && (cpu_i.halt || cpu_i.stop || state == MWDT_ST_WAIT ||
    (state == MWDT_ST_STOP && src == MWDT_SRC_X1));
  assign step = tick_sel && !paused;
  assign clear = mode_wr && !mode_written || kick_good;

  mwdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .clear_i(clear),
    .step_i(step),
    .exp_i(period_exp(mode[2:0], src)),
    .count_o(count),
    .overflow_o(overflow)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bad_mode_seen <= 1'b0;
      bad_kick_seen <= 1'b0;
      ovf_seen <= 1'b0;
    end else begin
      bad_mode_seen <= mode_again;
      bad_kick_seen <= kick_bad;
      ovf_seen <= overflow;
    end
  end

  assign wdt_reset_o = bad_mode_seen || bad_kick_seen || ovf_seen;

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      if (hit_mode) begin
        rdata_o <= mode;
      end else if (hit_kick) begin
        rdata_o <= `MWDT_KICK_READ;
      end else if (hit_ctrl) begin
        rdata_o <= 8'(ost_len);
      end else if (hit_stat) begin
        rdata_o <= {4'h0, state};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_kick_clears;
    @(posedge clk_sys_i) disable iff (!arst_n_i) kick_good |=> count == '0;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("key write did not clear counter");

  property p_bad_kick_reset;
    @(posedge clk_sys_i) disable iff (!arst_n_i) kick_bad |=> wdt_reset_o;
  endproperty
  a_bad_kick_reset: assert property (p_bad_kick_reset) else $error("bad kick gave no reset");

  property p_second_mode;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (mode_wr && mode_written && src != MWDT_SRC_STOP) |=> wdt_reset_o;
  endproperty
  a_second_mode: assert property (p_second_mode) else $error("second mode write gave no reset");

  property p_mode_clears;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (mode_wr && !mode_written) |=> count == '0;
  endproperty
  a_mode_clears: assert property (p_mode_clears) else $error("mode write did not clear counter");

  property p_ovf_reset;
    @(posedge clk_sys_i) disable iff (!arst_n_i) overflow |=> wdt_reset_o;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow gave no reset");

  property p_fixed_low;
    @(posedge clk_sys_i) disable iff (!arst_n_i) !stoppable_i |-> src == MWDT_SRC_LOW && state == MWDT_ST_RUN;
  endproperty
  a_fixed_low: assert property (p_fixed_low) else $error("fixed option left low clock");

  property p_halt_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (stoppable_i && cpu_i.halt && !clear) |=> $stable(count);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counter moved in halt");

  property p_stop_quiet;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (src == MWDT_SRC_STOP) |=> !wdt_reset_o;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("stopped watchdog raised misuse reset");

  property p_stop_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (stoppable_i && cpu_i.stop && !clear) |=> $stable(count);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved in stop");

  property p_stop_enter;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (stoppable_i && state == MWDT_ST_RUN && cpu_i.stop) |=> state == MWDT_ST_STOP;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop did not pause watchdog");

  property p_halt_enter;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (stoppable_i && state == MWDT_ST_RUN && cpu_i.halt && !cpu_i.stop) |=> state == MWDT_ST_HALT;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt did not pause watchdog");

  property p_halt_resume;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (state == MWDT_ST_HALT && !cpu_i.halt && !cpu_i.stop && tick_sel && !clear)
      |=> count == $past(count) + {{(CNT_W-1){1'b0}}, 1'b1};
  endproperty
  a_halt_resume: assert property (p_halt_resume) else $error("count lost at halt release");

  property p_low_resume;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (state == MWDT_ST_STOP && !cpu_i.stop && !cpu_i.halt && src == MWDT_SRC_LOW && cpu_i.tick_low && !clear)
      |=> count == $past(count) + {{(CNT_W-1){1'b0}}, 1'b1};
  endproperty
  a_low_resume: assert property (p_low_resume) else $error("low clock did not resume at once");

  property p_x1_wait;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (state == MWDT_ST_STOP && !cpu_i.stop && src == MWDT_SRC_X1) |=> state == MWDT_ST_WAIT;
  endproperty
  a_x1_wait: assert property (p_x1_wait) else $error("x1 clock skipped stabilization wait");

  property p_wait_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (state == MWDT_ST_WAIT && !clear) |=> $stable(count);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("counter moved in stabilization wait");

  property p_cpu_switch;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (state == MWDT_ST_WAIT && cpu_i.cpu_on_x1 && !cpu_on_x1_at_stop) |=> state == MWDT_ST_RUN;
  endproperty
  a_cpu_switch: assert property (p_cpu_switch) else $error("cpu clock switch did not resume");

  property p_fixed_runs;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (!stoppable_i && cpu_i.tick_low && !clear) |=> count == $past(count) + {{(CNT_W-1){1'b0}}, 1'b1};
  endproperty
  a_fixed_runs: assert property (p_fixed_runs) else $error("fixed option missed a tick");

  property p_kick_read;
    @(posedge clk_sys_i) disable iff (!arst_n_i) (bus_i.rd && hit_kick) |=> rdata_o == `MWDT_KICK_READ;
  endproperty
  a_kick_read: assert property (p_kick_read) else $error("kick register read wrong value");
endmodule : mwdt_top
`default_nettype wire

/* File: bench/microcontroller_watchdog_timer_tb.sv */
// Self-checking bench of the watchdog timer top against a cycle model.
`timescale 1ns/1ps
`default_nettype none
`include "mwdt_map.svh"
module microcontroller_watchdog_timer_tb;
  import mwdt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic stoppable_i = 1'b1;
  mwdt_bus_t bus = '0;
  mwdt_cpu_t cpu = '0;
  logic [7:0] rdata_o;
  logic wdt_reset_o;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] rng = 32'h0000_0025;
  int cnt;
  int lim;
  logic done_wr;
  logic [7:0] mode;
  logic exp_rst;
  logic stopped;
  logic tick;
  logic bad;
  logic clr;
  logic ovf;
  int cpu_x1 = 2;
  int ost_m;
  int ost_len_m;
  logic waiting;
  logic in_stop;
  logic at_stop;
  logic x1src;
  logic hold;

  mwdt_top i_dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .stoppable_i(stoppable_i),
    .bus_i(bus),
    .rdata_o(rdata_o),
    .cpu_i(cpu),
    .wdt_reset_o(wdt_reset_o)
  );

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt = 0;
      done_wr = 1'b0;
      mode = `MWDT_MODE_RESET;
      waiting = 1'b0;
      in_stop = 1'b0;
      at_stop = 1'b0;
      ost_m = 0;
      ost_len_m = `MWDT_OST_RESET;
      exp_rst <= 1'b0;
    end else begin
      stopped = stoppable_i && mode[`MWDT_CS_HI];
      x1src = stoppable_i && !mode[`MWDT_CS_HI] && mode[`MWDT_CS_LO];
      tick = x1src ? cpu.tick_x1 : cpu.tick_low;
      lim = (1 << (x1src ? `MWDT_X1_EXP_BASE + mode[2:0] : `MWDT_LOW_EXP_BASE + mode[2:0])) - 1;
      hold = stoppable_i && (cpu.halt || cpu.stop || waiting || (in_stop && x1src));
      bad = 1'b0;
      clr = 1'b0;
      if (bus.wr && bus.addr == `MWDT_ADDR_KICK) begin
        if (bus.bit_op || bus.wdata != `MWDT_KICK_KEY) begin
          bad = 1'b1;
        end else begin
          clr = 1'b1;
        end
      end
      if (bus.wr && bus.addr == `MWDT_ADDR_MODE) begin
        if (done_wr || bus.bit_op) begin
          bad = 1'b1;
        end else begin
          mode = {`MWDT_FIXED_HI, bus.wdata[4:0]};
          done_wr = 1'b1;
          clr = 1'b1;
        end
      end
      ovf = !stopped && tick && !clr && !hold && cnt == lim;
      if (clr) begin
        cnt = 0;
      end else if (!stopped && tick && !hold) begin
        cnt = cnt + 1;
      end
      if (waiting) begin
        if (cpu.tick_x1 && ost_m == ost_len_m - 1) begin
          waiting = 1'b0;
        end else if (cpu.cpu_on_x1 && !at_stop) begin
          waiting = 1'b0;
        end else if (cpu.tick_x1) begin
          ost_m = ost_m + 1;
        end
      end
      if (stoppable_i && cpu.stop && !in_stop) begin
        in_stop = 1'b1;
        at_stop = cpu.cpu_on_x1;
      end else if (in_stop && !cpu.stop) begin
        in_stop = 1'b0;
        waiting = x1src;
        ost_m = 0;
      end
      if (bus.wr && bus.addr == `MWDT_ADDR_CTRL) begin
        ost_len_m = bus.wdata;
      end
      exp_rst <= ovf || (bad && !stopped);
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic rst(input logic opt);
    arst_n_i <= 1'b0;
    stoppable_i <= opt;
    cpu.halt <= 1'b0;
    cpu.stop <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask : rst

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    bus.addr <= a;
    bus.wdata <= d;
    bus.bit_op <= b;
    bus.wr <= 1'b1;
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
    bus.bit_op <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    @(negedge clk_sys_i);
    check(rdata_o, e);
    @(posedge clk_sys_i);
  endtask : rd

  task automatic run(input int n, input logic dense);
    repeat (n) begin
      rng = xs(rng);
      cpu.tick_low <= dense | rng[0];
      cpu.tick_x1 <= dense | rng[1];
      cpu.cpu_on_x1 <= (cpu_x1 == 2) ? rng[2] : cpu_x1[0];
      @(posedge clk_sys_i);
    end
  endtask : run

  always @(negedge clk_sys_i) begin
    if (arst_n_i) begin
      check({7'h00, wdt_reset_o}, {7'h00, exp_rst});
    end
  end

  initial begin
    #1_000_000;
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst(1'b1);
    rd(`MWDT_ADDR_MODE, `MWDT_MODE_RESET);
    rd(`MWDT_ADDR_KICK, `MWDT_KICK_READ);
    rd(8'h10, 8'h00);
    run(4200, 1'b1);
    wr(`MWDT_ADDR_MODE, 8'h60, 1'b0);
    run(1500, 1'b0);
    wr(`MWDT_ADDR_KICK, `MWDT_KICK_KEY, 1'b0);
    run(1500, 1'b0);
    cpu.halt <= 1'b1;
    run(3000, 1'b0);
    cpu.halt <= 1'b0;
    cpu.stop <= 1'b1;
    run(300, 1'b0);
    cpu.stop <= 1'b0;
    run(3000, 1'b0);
    wr(`MWDT_ADDR_MODE, 8'h60, 1'b0);
    run(4, 1'b0);
    rst(1'b1);
    wr(`MWDT_ADDR_MODE, 8'h68, 1'b0);
    run(4000, 1'b1);
    cpu.halt <= 1'b1;
    run(500, 1'b1);
    cpu.halt <= 1'b0;
    run(4500, 1'b1);
    wr(`MWDT_ADDR_KICK, 8'h55, 1'b0);
    wr(`MWDT_ADDR_KICK, `MWDT_KICK_KEY, 1'b1);
    for (int i = 0; i < 2; i++) begin
      rst(1'b1);
      wr(`MWDT_ADDR_MODE, i ? 8'h78 : 8'h70, 1'b0);
      run(5000, 1'b1);
      wr(`MWDT_ADDR_MODE, 8'h60, 1'b0);
      wr(`MWDT_ADDR_KICK, 8'h55, 1'b0);
      wr(`MWDT_ADDR_KICK, `MWDT_KICK_KEY, 1'b1);
      run(4, 1'b1);
    end
    for (int j = 0; j < 2; j++) begin
      rst(1'b1);
      cpu_x1 = j ? 0 : 1;
      wr(`MWDT_ADDR_CTRL, 8'h20, 1'b0);
      rd(`MWDT_ADDR_CTRL, 8'h20);
      wr(`MWDT_ADDR_MODE, 8'h68, 1'b0);
      run(100, 1'b1);
      cpu.stop <= 1'b1;
      run(50, 1'b1);
      rd(`MWDT_ADDR_STAT, {4'h0, MWDT_ST_STOP});
      cpu.stop <= 1'b0;
      run(2, 1'b1);
      rd(`MWDT_ADDR_STAT, {4'h0, MWDT_ST_WAIT});
      cpu_x1 = 1;
      run(8300, 1'b1);
    end
    rst(1'b0);
    wr(`MWDT_ADDR_MODE, 8'h78, 1'b0);
    cpu.stop <= 1'b1;
    run(2200, 1'b1);
    cpu.stop <= 1'b0;
    wr(`MWDT_ADDR_KICK, `MWDT_KICK_KEY, 1'b1);
    run(4, 1'b1);
    end_of_test();
  end
endmodule : microcontroller_watchdog_timer_tb
`default_nettype wire
